// ### hdl/ttd_regs.svh
`ifndef TTD_REGS_SVH
`define TTD_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define TTD_ADDR_STATUS 8'h00
`define TTD_ADDR_TTL0 8'h29
`define TTD_ADDR_RTL0 8'h2a
`define TTD_ADDR_TTL1 8'h2b
`define TTD_ADDR_RTL1 8'h2c
`define TTD_ADDR_TTL2 8'h2d
`define TTD_ADDR_RTL2 8'h2e

// ****************************************************************
// fields, reset values, counts
// ****************************************************************
`define TTD_NUM_PADS 3
`define TTD_LVL_MSB 7
`define TTD_LVL_RESET 8'h00
`define TTD_STATUS_RESET 3'h0
`define TTD_BYTE_BITS 4'h8
`define TTD_LAST_TX_BIT 4'h7

`endif

// ### hdl/ttd_pkg.sv
`include "ttd_regs.svh"

package ttd_pkg;

    // ****************************************************************
    // serial slave states and byte phases
    // ****************************************************************
    typedef enum logic [2:0] {
        TTD_IDLE = 3'b000,
        TTD_RECV = 3'b001,
        TTD_ACK  = 3'b010,
        TTD_SEND = 3'b011,
        TTD_MACK = 3'b100
    } ttd_state_t;

    typedef enum logic [1:0] {
        TTD_PH_ADDR = 2'b00,
        TTD_PH_PTR  = 2'b01,
        TTD_PH_DATA = 2'b10
    } ttd_phase_t;

    // ****************************************************************
    // level register decode
    // ****************************************************************
    // true when the pointer hits one of the six trip level registers
    function automatic logic ttd_is_lvl(input logic [7:0] ptr);
        return (ptr >= `TTD_ADDR_TTL0) && (ptr <= `TTD_ADDR_RTL2);
    endfunction

    // pad index of a trip level register
    function automatic logic [1:0] ttd_lvl_pad(input logic [7:0] ptr);
        logic [7:0] off;
        off = ptr - `TTD_ADDR_TTL0;
        return off[2:1];
    endfunction

    // touch levels sit at odd offsets, release levels at even ones
    function automatic logic ttd_is_touch(input logic [7:0] ptr);
        return ptr[0];
    endfunction

endpackage

// ### hdl/ttd_pad_detector.sv
`timescale 1ns/1ps

module ttd_pad_detector
    import ttd_pkg::*;
#(
    parameter int DATA_W = 10
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic sample_valid,
    input wire logic pad_enable,
    input wire logic detect_enable,
    input wire logic [DATA_W-1:0] filtered,
    input wire logic [DATA_W-1:0] baseline,
    input wire logic [7:0] touch_level,
    input wire logic [7:0] release_level,
    output logic touched,
    output logic change
);

    logic [DATA_W-1:0] delta;
    logic [DATA_W-1:0] touch_ext;
    logic [DATA_W-1:0] release_ext;
    logic take;
    logic hit_touch;
    logic hit_release;

    // ****************************************************************
    // delta and comparisons
    // ****************************************************************
    // a press lowers the count, a rise above baseline is no touch unless the pad's touch_level is zero
    assign delta = (baseline > filtered) ? baseline - filtered
                                         : '0;
    assign touch_ext = DATA_W'(touch_level);
    assign release_ext = DATA_W'(release_level);
    assign take = sample_valid & pad_enable;
    assign hit_touch = detect_enable && (delta >= touch_ext);
    assign hit_release = !detect_enable || (delta <= release_ext);

    // touch state, held until release; freezes the baseline meanwhile
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            touched <= 1'b0;
        end else if (take) begin
            if (!touched && hit_touch) begin
                touched <= 1'b1;
            end else if (touched && hit_release) begin
                touched <= 1'b0;
            end
        end
    end

    // one pulse per state change
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            change <= 1'b0;
        end else begin
            change <= take && (touched ? hit_release : hit_touch);
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_touch_cause;
        take && !touched && detect_enable && (delta >= touch_ext);
    endsequence

    sequence s_release_cause;
        take && touched && detect_enable && (delta <= release_ext);
    endsequence

    a_touch_entry: assert property (
        s_touch_cause |=> touched && change)
        else $error("touch not declared at trip level");

    a_release_entry: assert property (
        s_release_cause |=> !touched && change)
        else $error("release not declared at trip level");

    a_hold_kept: assert property (
        touched && !take |=> touched && !change)
        else $error("baseline hold dropped without a sample");

    a_detect_off: assert property (
        !touched && !detect_enable |=> !touched)
        else $error("touch declared while detection disabled");

    a_press_sense: assert property (
        take && !touched && (filtered >= baseline) && (touch_level != 8'h00)
        |=> !touched)
        else $error("touch declared on a rising count");

    a_single_event: assert property (
        !take |=> !change)
        else $error("state change without a new sample");

endmodule

// ### hdl/ttd_top.sv
`timescale 1ns/1ps

module ttd_top
    import ttd_pkg::*;
#(
    parameter int DATA_W = 10,
    parameter logic [6:0] DEV_ADDR = 7'h2a // value is arbitrary
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [2:0] sample_valid,
    input wire logic [2:0] pad_enable,
    input wire logic [DATA_W-1:0] filtered_pad_zero,
    input wire logic [DATA_W-1:0] filtered_pad_one,
    input wire logic [DATA_W-1:0] filtered_pad_two,
    input wire logic [DATA_W-1:0] baseline_pad_zero,
    input wire logic [DATA_W-1:0] baseline_pad_one,
    input wire logic [DATA_W-1:0] baseline_pad_two,
    output logic [2:0] baseline_hold,
    output logic [2:0] touch_status,
    output logic irq_req
);

    localparam int NP = `TTD_NUM_PADS;

    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    ttd_state_t state;
    ttd_phase_t phase;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] txreg;
    logic [7:0] ptr;
    logic rw;
    logic mnack;
    logic wr_strobe;
    logic [7:0] touch_lvl [NP];
    logic [7:0] release_lvl [NP];
    logic [DATA_W-1:0] filt [NP];
    logic [DATA_W-1:0] base [NP];
    logic [NP-1:0] touched;
    logic [NP-1:0] pad_change;
    logic detect_enable;

    // ****************************************************************
    // pin synchronisers and bus conditions
    // ****************************************************************
    // two flops per pin, a third copy for edge detection
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_seen = scl_s && scl_d && sda_d && !sda_s;
    assign stop_seen = scl_s && scl_d && !sda_d && sda_s;

    // ****************************************************************
    // register read
    // ****************************************************************
    // status and trip levels; unmapped offsets read zero
    function automatic logic [7:0] reg_read(input logic [7:0] p);
        logic [1:0] pad;
        pad = ttd_lvl_pad(p);
        if (p == `TTD_ADDR_STATUS) begin
            return {5'h00, touched};
        end else if (ttd_is_lvl(p)) begin
            return ttd_is_touch(p) ? touch_lvl[pad] : release_lvl[pad];
        end else begin
            return 8'h00;
        end
    endfunction

    // ****************************************************************
    // serial slave
    // ****************************************************************
    // address byte, pointer byte, then data bytes with auto increment
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= TTD_IDLE;
            phase <= TTD_PH_ADDR;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            txreg <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            mnack <= 1'b0;
        end else if (start_seen) begin
            state <= TTD_RECV;
            phase <= TTD_PH_ADDR;
            bitcnt <= 4'h0;
        end else if (stop_seen) begin
            state <= TTD_IDLE;
        end else if (scl_rise) begin
            case (state)
                TTD_RECV: begin
                    shreg <= {shreg[6:0], sda_s};
                    bitcnt <= bitcnt + 4'h1;
                end
                TTD_MACK: begin
                    mnack <= sda_s;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state)
                TTD_RECV: begin
                    if (bitcnt == `TTD_BYTE_BITS) begin
                        if (phase == TTD_PH_ADDR) begin
                            if (shreg[7:1] == DEV_ADDR) begin
                                state <= TTD_ACK;
                                rw <= shreg[0];
                            end else begin
                                state <= TTD_IDLE;
                            end
                        end else if (phase == TTD_PH_PTR) begin
                            ptr <= shreg;
                            state <= TTD_ACK;
                        end else begin
                            state <= TTD_ACK;
                        end
                    end
                end
                TTD_ACK: begin
                    bitcnt <= 4'h0;
                    if (rw) begin
                        txreg <= reg_read(ptr);
                        ptr <= ptr + 8'h01;
                        state <= TTD_SEND;
                    end else begin
                        state <= TTD_RECV;
                        if (phase == TTD_PH_ADDR) begin
                            phase <= TTD_PH_PTR;
                        end else if (phase == TTD_PH_PTR) begin
                            phase <= TTD_PH_DATA;
                        end else begin
                            ptr <= ptr + 8'h01;
                        end
                    end
                end
                TTD_SEND: begin
                    if (bitcnt == `TTD_LAST_TX_BIT) begin
                        state <= TTD_MACK;
                    end else begin
                        txreg <= {txreg[6:0], 1'b0};
                        bitcnt <= bitcnt + 4'h1;
                    end
                end
                TTD_MACK: begin
                    if (mnack) begin
                        state <= TTD_IDLE;
                    end else begin
                        txreg <= reg_read(ptr);
                        ptr <= ptr + 8'h01;
                        bitcnt <= 4'h0;
                        state <= TTD_SEND;
                    end
                end
                default: begin
                    state <= TTD_IDLE;
                end
            endcase
        end
    end

    // open-drain data line: pull low for ack and for zero bits
    assign sda_out = 1'b0;
    assign sda_oe = (state == TTD_ACK) || ((state == TTD_SEND) && !txreg[7]);
    assign wr_strobe = scl_fall && !start_seen && !stop_seen
                       && (state == TTD_RECV) && (bitcnt == `TTD_BYTE_BITS)
                       && (phase == TTD_PH_DATA);

    // ****************************************************************
    // trip level registers
    // ****************************************************************
    // one touch and one release byte per pad
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NP; i++) begin
                touch_lvl[i] <= `TTD_LVL_RESET;
                release_lvl[i] <= `TTD_LVL_RESET;
            end
        end else if (wr_strobe && ttd_is_lvl(ptr)) begin
            if (ttd_is_touch(ptr)) begin
                touch_lvl[ttd_lvl_pad(ptr)] <= shreg;
            end else begin
                release_lvl[ttd_lvl_pad(ptr)] <= shreg;
            end
        end
    end

    // ****************************************************************
    // per pad detection
    // ****************************************************************
    assign filt[0] = filtered_pad_zero;
    assign filt[1] = filtered_pad_one;
    assign filt[2] = filtered_pad_two;
    assign base[0] = baseline_pad_zero;
    assign base[1] = baseline_pad_one;
    assign base[2] = baseline_pad_two;
    // all touch levels zero turns the third stage into a plain filter
    assign detect_enable = (touch_lvl[0] != 8'h00) || (touch_lvl[1] != 8'h00)
                           || (touch_lvl[2] != 8'h00);

    for (genvar g = 0; g < NP; g++) begin : g_pad
        ttd_pad_detector #(
            .DATA_W(DATA_W)
        ) u_det (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .sample_valid(sample_valid[g]),
            .pad_enable(pad_enable[g]),
            .detect_enable(detect_enable),
            .filtered(filt[g]),
            .baseline(base[g]),
            .touch_level(touch_lvl[g]),
            .release_level(release_lvl[g]),
            .touched(touched[g]),
            .change(pad_change[g])
        );
    end

    // freeze and status follow the touch state
    assign baseline_hold = touched;
    assign touch_status = touched;

    // interrupt pulse on any touch or release
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= |pad_change;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_irq_follow: assert property (
        $rose(touch_status[0]) |=> irq_req)
        else $error("touch without interrupt request");

    a_release_irq: assert property (
        $fell(touch_status[1]) |=> irq_req && !baseline_hold[1])
        else $error("release without interrupt or resume");

    a_status_reads: assert property (
        (state == TTD_ACK) && rw && scl_fall && !start_seen
        && !stop_seen && (ptr == `TTD_ADDR_STATUS)
        |=> txreg[2:0] == $past(touched))
        else $error("status read does not show touch state");

    a_lvl_write: assert property (
        wr_strobe && (ptr == `TTD_ADDR_TTL1)
        |=> touch_lvl[1] == $past(shreg) && touch_lvl[0] == $past(touch_lvl[0]))
        else $error("touch level write misplaced");

    a_rel_write: assert property (
        wr_strobe && (ptr == `TTD_ADDR_RTL2)
        |=> release_lvl[2] == $past(shreg))
        else $error("release level write misplaced");

endmodule

// ### dv/ttd_host_model.sv
`timescale 1ns/1ps

// ********************
// host controller: i2c master, open-drain data
// ********************
module ttd_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2a, // value is arbitrary
    parameter int HALF = 30
) (
    input wire logic ref_clk,
    input wire logic sda_oe,
    output logic scl_in,
    output logic sda_in
);
    logic pull;

    // pull-up: a released line reads high
    assign sda_in = ~(pull | sda_oe);

    initial begin
        scl_in <= 1'b1;
        pull <= 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // data moves a quarter into scl low, is sampled mid-high
    task automatic bit_io(input logic b, output logic seen);
        tick(HALF / 4);
        pull <= ~b;
        tick(HALF - HALF / 4);
        scl_in <= 1'b1;
        tick(HALF / 2);
        seen = sda_in;
        tick(HALF / 2);
        scl_in <= 1'b0;
    endtask

    // start: data falls while scl high; stop: data rises
    task automatic cond(input logic start);
        tick(HALF / 4);
        pull <= ~start;
        tick(HALF - HALF / 4);
        scl_in <= 1'b1;
        tick(HALF / 2);
        pull <= start;
        tick(HALF / 2);
        if (start) begin
            scl_in <= 1'b0;
        end
    endtask

    // eight bits out and in, then the ninth bit
    task automatic xfer(input logic [7:0] tx, input logic ab,
                        output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], s);
            rx[i] = s;
        end
        bit_io(ab, s);
        ack = ~s;
    endtask

    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                             input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic a0, a1, a2;
        cond(1'b1);
        xfer({dev, 1'b0}, 1'b1, r, a0);
        xfer(ptr, 1'b1, r, a1);
        xfer(d, 1'b1, r, a2);
        cond(1'b0);
        ok = a0 & a1 & a2;
    endtask

    // the single data byte is closed with a nack
    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d,
                            output logic ok);
        logic a0, a1, a2, s;
        cond(1'b1);
        xfer({DEV_ADDR, 1'b0}, 1'b1, d, a0);
        xfer(ptr, 1'b1, d, a1);
        cond(1'b1);
        xfer({DEV_ADDR, 1'b1}, 1'b1, d, a2);
        xfer(8'hff, 1'b1, d, s);
        cond(1'b0);
        ok = a0 & a1 & a2;
    endtask
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ps
`include "ttd_regs.svh"

module testbench;
    localparam logic [6:0] DEV = 7'h2a; // value is arbitrary
    localparam logic [7:0] CFG [6] = '{8'h20, 8'h10, 8'hff, 8'h00,
                                       8'h05, 8'h02};
    logic ref_clk;
    logic reset_n;
    logic scl_in;
    logic sda_in;
    logic sda_out;
    logic sda_oe;
    logic [2:0] sample_valid;
    logic [2:0] pad_enable;
    logic [9:0] filt [3];
    logic [9:0] base [3];
    logic [2:0] baseline_hold;
    logic [2:0] touch_status;
    logic irq_req;
    logic [7:0] lvl [6];
    logic [2:0] exp_touch = 3'h0;
    logic ok;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;

    ttd_top #(.DEV_ADDR(DEV)) DUT (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .sample_valid(sample_valid),
        .pad_enable(pad_enable),
        .filtered_pad_zero(filt[0]),
        .filtered_pad_one(filt[1]),
        .filtered_pad_two(filt[2]),
        .baseline_pad_zero(base[0]),
        .baseline_pad_one(base[1]),
        .baseline_pad_two(base[2]),
        .baseline_hold(baseline_hold),
        .touch_status(touch_status),
        .irq_req(irq_req)
    );

    ttd_host_model #(.DEV_ADDR(DEV)) host (
        .ref_clk(ref_clk),
        .sda_oe(sda_oe),
        .scl_in(scl_in),
        .sda_in(sda_in)
    );

    // ********************
    // clock, hang limit, reporting
    // ********************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            miscompares = miscompares + 1;
            close_out();
        end
    end

    task close_out();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // ********************
    // register access and sample tasks
    // ********************
    task wr(input logic [7:0] a, input logic [7:0] d);
        host.write_reg(DEV, a, d, ok);
        check({7'h0, ok}, 8'h01);
    endtask

    task rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(a, d, ok);
        check({7'h0, ok}, 8'h01);
        check(d, exp);
    endtask

    // one sample on pad p; expected state kept from the levels written
    task sample(input int p, input logic [9:0] b, input logic [9:0] f);
        logic [9:0] delta;
        logic on;
        logic [2:0] was;
        @(posedge ref_clk);
        delta = (b > f) ? b - f : 10'h000;
        on = |{lvl[0], lvl[2], lvl[4]};
        was = exp_touch;
        if (pad_enable[p] && !was[p]) begin
            exp_touch[p] = on && (delta >= {2'b00, lvl[2 * p]});
        end else if (pad_enable[p]) begin
            exp_touch[p] = on && (delta > {2'b00, lvl[2 * p + 1]});
        end
        base[p] <= b;
        filt[p] <= f;
        sample_valid <= 3'b001 << p;
        @(posedge ref_clk);
        sample_valid <= 3'b000;
        @(posedge ref_clk);
        #1;
        check({5'h0, touch_status}, {5'h0, exp_touch});
        check({5'h0, baseline_hold}, {5'h0, exp_touch});
        check({7'h0, irq_req}, {7'h0, was != exp_touch});
        @(posedge ref_clk);
        #1;
        check({7'h0, irq_req}, 8'h00);
    endtask

    // ********************
    // main sequence
    // ********************
    initial begin
        reset_n <= 1'b0;
        sample_valid <= 3'b000;
        pad_enable <= 3'b011;
        for (int i = 0; i < 3; i++) begin
            filt[i] <= 10'h200;
            base[i] <= 10'h200;
        end
        for (int i = 0; i < 6; i++) begin
            lvl[i] = 8'h00;
        end
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        #1;
        check({5'h0, touch_status | baseline_hold}, 8'h00);
        check({6'h0, irq_req, sda_out}, 8'h00);
        for (int i = 0; i < 6; i++) begin
            rd(`TTD_ADDR_TTL0 + i[7:0], 8'h00);
        end
        sample(0, 10'h200, 10'h100);
        for (int i = 0; i < 6; i++) begin
            wr(`TTD_ADDR_TTL0 + i[7:0], CFG[i]);
            lvl[i] = CFG[i];
        end
        for (int i = 0; i < 6; i++) begin
            rd(`TTD_ADDR_TTL0 + i[7:0], CFG[i]);
        end
        // unmapped places and a foreign device address change nothing
        wr(8'h2f, 8'h55);
        rd(8'h2f, 8'h00);
        rd(8'h28, 8'h00);
        host.write_reg(DEV ^ 7'h01, `TTD_ADDR_TTL0, 8'h77, ok);
        check({7'h0, ok}, 8'h00);
        rd(`TTD_ADDR_TTL0, 8'h20);
        // pad zero: rise in counts, one below trip, at trip, hold, release
        sample(0, 10'h200, 10'h240);
        sample(0, 10'h200, 10'h1e1);
        sample(0, 10'h200, 10'h1e0);
        sample(0, 10'h200, 10'h1e0);
        sample(0, 10'h200, 10'h1ef);
        sample(0, 10'h200, 10'h1f0);
        // pad one: full-scale touch level, zero release level
        sample(1, 10'h12c, 10'h02e);
        sample(1, 10'h12c, 10'h02d);
        sample(1, 10'h12c, 10'h12b);
        sample(1, 10'h12c, 10'h12c);
        // pad two ignored while disabled, then its own level applies
        sample(2, 10'h200, 10'h100);
        @(posedge ref_clk);
        pad_enable <= 3'b111;
        sample(2, 10'h010, 10'h00b);
        sample(0, 10'h200, 10'h1c0);
        rd(`TTD_ADDR_STATUS, 8'h05);
        // all touch levels zero: touched pads release, no new touch
        for (int i = 0; i < 3; i++) begin
            wr(`TTD_ADDR_TTL0 + 8'(2 * i), 8'h00);
            lvl[2 * i] = 8'h00;
        end
        sample(0, 10'h200, 10'h1c0);
        sample(2, 10'h010, 10'h000);
        sample(1, 10'h200, 10'h000);
        close_out();
    end
endmodule
